// >>> src/mad_pkg.sv
/*
 * Package of the motion activity detector: register offsets, field positions,
 * reset values and timing constants.
 * Assumes a 20 MHz core clock and a 32-bit AHB-Lite register bus.
 */
package mad_pkg;

	// ========================================================================
	// Register map (byte addresses)
	// ========================================================================
	// The control register is numbered by word index; its byte address is four
	// times that index, so every register stays one aligned word.
	localparam logic [7:0] MAD_IDX_CONTROL   = 8'h27; // motion_detect_control
	localparam logic [7:0] MAD_OFS_CONTROL   = {MAD_IDX_CONTROL[5:0], 2'h0};
	localparam logic [7:0] MAD_OFS_ACT_THR   = 8'h28;
	localparam logic [7:0] MAD_OFS_ACT_TIME  = 8'h2C;
	localparam logic [7:0] MAD_OFS_INACT_THR = 8'h30;
	localparam logic [7:0] MAD_OFS_INACT_TIM = 8'h34;
	localparam logic [7:0] MAD_OFS_MODE      = 8'h38;
	localparam logic [7:0] MAD_OFS_STATUS    = 8'h3C;
	localparam logic [7:0] MAD_OFS_REFS      = 8'h40;

	// ========================================================================
	// Control register fields
	// ========================================================================
	localparam int MAD_CTL_ACT_LO   = 0;
	localparam int MAD_CTL_INACT_LO = 2;
	localparam int MAD_CTL_LINK_LO  = 4;
	localparam logic [1:0] MAD_EN_OFF = 2'h0;
	localparam logic [1:0] MAD_EN_ABS = 2'h1;
	localparam logic [1:0] MAD_EN_REF = 2'h3;
	localparam logic [1:0] MAD_LINK_DEFAULT = 2'h0;
	localparam logic [1:0] MAD_LINK_LINKED  = 2'h1;
	localparam logic [1:0] MAD_LINK_LOOP    = 2'h3;
	localparam logic [7:0] MAD_CTL_RESET    = 8'h00;

	// Mode register fields.
	localparam int MAD_MODE_MEAS  = 0;
	localparam int MAD_MODE_WAKE  = 1;
	localparam int MAD_MODE_AXIS  = 4;
	localparam int MAD_MODE_IRQ_A = 8;
	localparam int MAD_MODE_IRQ_I = 9;
	localparam logic [9:0] MAD_MODE_RESET = 10'h070;

	// Status register fields.
	localparam int MAD_ST_ACT   = 0;
	localparam int MAD_ST_INACT = 1;
	localparam int MAD_ST_AWAKE = 2;

	// ========================================================================
	// Timing
	// ========================================================================
	localparam int MAD_ACT_TIME_W   = 16;
	localparam int MAD_INACT_TIME_W = 16;
	localparam int MAD_ACT_MAX_S    = 20;
	localparam int MAD_ODR_MAX_HZ   = 400;
	localparam int MAD_ACT_MAX_SAMP = MAD_ACT_MAX_S * MAD_ODR_MAX_HZ;

endpackage

// >>> src/mad_motion_activity_detector.sv
/*
 * Motion activity and inactivity detector with an AHB-Lite register slave.
 * Assumes samples arrive from logic on core_clk with a one-cycle strobe at
 * the output data rate, and a single AHB-Lite master.
 */
// The AHB-Lite register port is this design's own decision.
// Overview of operation
// - Activity when any enabled axis exceeds threshold for activity time.
// - Absolute activity compares raw sample magnitude to threshold.
// - Referenced configuration when either enable field equals 11.
// - Referenced activity uses absolute difference from stored reference.
// - Activity reference captured at start, after linked inactivity, unlinked repeat.
// - First measurement entry uses absolute compares until reference captured.
// - Activity timer spans one sample up to 20 seconds.
// - Wake-up mode uses single-sample activity; measurement mode uses timer.
// - Inactivity only when every enabled axis stays below threshold.
// - Absolute inactivity counts consecutive quiet samples to programmed time.
// - Referenced inactivity compares difference from inactivity reference.
// - Inactivity reference captured at entry and each inactivity event.
// - Inactivity reference not refreshed before timer expires.
// - Inactivity timer counts 1 to 65535 output samples.
// - Events set status flags and optionally drive interrupt outputs.
// - Detection runs in measurement mode and wake-up mode.
// - Both detectors disabled after reset.
// - Default mode keeps both enabled; flags latch until host reads.
// - Linked mode arms only one detector at a time.
// - Linked mode arms activity first; next after host services event.
// - Awake flag is 1 at reset, follows cleared events.
// - Loop mode alternates like linked mode but clears events itself.
`timescale 1ns/1ps
module mad_motion_activity_detector
	import mad_pkg::*;
#(
	parameter int SAMPLE_W = 14
) (
	// Clock and reset
	input  wire  logic                core_clk,
	input  wire  logic                nrst,
	// AHB-Lite slave
	input  wire  logic                hsel,
	input  wire  logic [31:0]         haddr,
	input  wire  logic [1:0]          htrans,
	input  wire  logic                hwrite,
	input  wire  logic [2:0]          hsize,
	input  wire  logic [31:0]         hwdata,
	input  wire  logic                hready,
	output logic       [31:0]         hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// Sample stream
	input  wire  logic                sampleTick,
	input  wire  logic [SAMPLE_W-1:0] sampleX,
	input  wire  logic [SAMPLE_W-1:0] sampleY,
	input  wire  logic [SAMPLE_W-1:0] sampleZ,
	// Event outputs
	output logic                      actIrq,
	output logic                      inactIrq,
	output logic                      awake
);
	import mad_pkg::*;

	// ========================================================================
	// Register storage
	// ========================================================================
	logic [7:0]                 ctl_q;
	logic [9:0]                 mode_q;
	logic [SAMPLE_W-1:0]        actThr_q;
	logic [SAMPLE_W-1:0]        inactThr_q;
	logic [MAD_ACT_TIME_W-1:0]  actTime_q;
	logic [MAD_INACT_TIME_W-1:0] inactTime_q;
	logic                       actFlag_q;
	logic                       inactFlag_q;
	logic                       awake_q;
	logic                       armAct_q;
	logic                       refValid_q;
	logic                       measPrev_q;
	logic [SAMPLE_W-1:0]        actRef_q [3];
	logic [SAMPLE_W-1:0]        inactRef_q [3];
	logic [MAD_ACT_TIME_W-1:0]  actCnt_q;
	logic [MAD_INACT_TIME_W-1:0] inactCnt_q;

	// AHB address phase capture.
	logic       dpValid_q;
	logic       dpWrite_q;
	logic [7:0] dpAddr_q;

	// ========================================================================
	// Decoded configuration
	// ========================================================================
	logic [1:0] actEn;
	logic [1:0] inactEn;
	logic [1:0] linkMode;
	logic       running;
	logic       wakeMode;
	logic       refCfg;
	logic       statusRead;

	assign actEn    = ctl_q[MAD_CTL_ACT_LO +: 2];
	assign inactEn  = ctl_q[MAD_CTL_INACT_LO +: 2];
	assign linkMode = ctl_q[MAD_CTL_LINK_LO +: 2];
	assign wakeMode = mode_q[MAD_MODE_WAKE];
	assign running  = mode_q[MAD_MODE_MEAS] | wakeMode;
	assign refCfg   = (actEn == MAD_EN_REF) || (inactEn == MAD_EN_REF);

	// ========================================================================
	// Per-axis comparison
	// ========================================================================
	logic [2:0] axisHigh;
	logic [2:0] axisLow;
	logic [SAMPLE_W-1:0] smp [3];
	assign smp[0] = sampleX;
	assign smp[1] = sampleY;
	assign smp[2] = sampleZ;

	// Two's-complement magnitude at output resolution.
	function automatic logic [SAMPLE_W-1:0] magOf(input logic [SAMPLE_W:0] v);
		logic [SAMPLE_W:0] m;
		m = v[SAMPLE_W] ? (~v + 1'b1) : v;
		return m[SAMPLE_W-1:0];
	endfunction

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			logic [SAMPLE_W-1:0] aMag;
			logic [SAMPLE_W-1:0] iMag;
			aMag = '0;
			iMag = '0;
			// Until a reference exists the referenced mode falls back to absolute.
			if (refCfg && refValid_q) begin
				aMag = magOf({smp[i][SAMPLE_W-1], smp[i]} - {actRef_q[i][SAMPLE_W-1], actRef_q[i]});
				iMag = magOf({smp[i][SAMPLE_W-1], smp[i]} - {inactRef_q[i][SAMPLE_W-1], inactRef_q[i]});
			end else begin
				aMag = magOf({smp[i][SAMPLE_W-1], smp[i]});
				iMag = aMag;
			end
			axisHigh[i] = mode_q[MAD_MODE_AXIS+i] && (aMag > actThr_q);
			axisLow[i]  = !mode_q[MAD_MODE_AXIS+i] || (iMag < inactThr_q);
		end
	end

	// ========================================================================
	// Detector arming and events
	// ========================================================================
	logic actArmed;
	logic inactArmed;
	logic actHit;
	logic inactHit;
	logic actEvent;
	logic inactEvent;
	logic enterMeas;
	logic linked;

	assign linked     = (linkMode == MAD_LINK_LINKED) || (linkMode == MAD_LINK_LOOP);
	// Linked mode waits for the host to service the pending flag.
	assign actArmed   = running && (actEn != MAD_EN_OFF) &&
		(!linked || (armAct_q && !(linkMode == MAD_LINK_LINKED && inactFlag_q)));
	assign inactArmed = running && (inactEn != MAD_EN_OFF) &&
		(!linked || (!armAct_q && !(linkMode == MAD_LINK_LINKED && actFlag_q)));
	assign actHit     = |axisHigh;
	assign inactHit   = &axisLow;
	assign enterMeas  = running && !measPrev_q;
	// Wake-up mode fires on one sample; actTime of 0 or 1 means no filtering.
	assign actEvent   = sampleTick && actArmed && actHit &&
		(wakeMode || ({1'b0, actCnt_q} + 17'h00001 >= {1'b0, actTime_q}));
	assign inactEvent = sampleTick && inactArmed && inactHit &&
		({1'b0, inactCnt_q} + 17'h00001 >= {1'b0, inactTime_q});

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			actCnt_q <= '0;
		end else if (!actArmed) begin
			actCnt_q <= '0;
		end else if (sampleTick) begin
			if (!actHit || actEvent) begin
				actCnt_q <= '0;
			end else if (actCnt_q != '1) begin
				actCnt_q <= actCnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			inactCnt_q <= '0;
		end else if (!inactArmed) begin
			inactCnt_q <= '0;
		end else if (sampleTick) begin
			if (!inactHit || inactEvent) begin
				inactCnt_q <= '0;
			end else if (inactCnt_q != '1) begin
				inactCnt_q <= inactCnt_q + 1'b1;
			end
		end
	end

	// Reference capture.
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			measPrev_q <= 1'b0;
			refValid_q <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				actRef_q[i]   <= '0;
				inactRef_q[i] <= '0;
			end
		end else begin
			measPrev_q <= running;
			if (!running) begin
				refValid_q <= 1'b0;
			end else if (sampleTick && !refValid_q) begin
				refValid_q <= 1'b1;
				for (int i = 0; i < 3; i++) begin
					actRef_q[i]   <= smp[i];
					inactRef_q[i] <= smp[i];
				end
			end else begin
				for (int i = 0; i < 3; i++) begin
					if ((inactEvent && linked) || (actEvent && !linked)) begin
						actRef_q[i] <= smp[i];
					end
					// Only an expired timer refreshes this one.
					if (inactEvent) begin
						inactRef_q[i] <= smp[i];
					end
				end
			end
		end
	end

	// ========================================================================
	// Flags, arming state and awake
	// ========================================================================
	logic loopClear;
	assign loopClear  = (linkMode == MAD_LINK_LOOP);
	assign statusRead = dpValid_q && !dpWrite_q && (dpAddr_q == MAD_OFS_STATUS);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			actFlag_q   <= 1'b0;
			inactFlag_q <= 1'b0;
			awake_q     <= 1'b1;
			armAct_q    <= 1'b1;
		end else begin
			// A new event wins over a read in the same cycle.
			if (actEvent) begin
				actFlag_q <= 1'b1;
			end else if (statusRead || (loopClear && inactEvent)) begin
				actFlag_q <= 1'b0;
			end
			if (inactEvent) begin
				inactFlag_q <= 1'b1;
			end else if (statusRead || (loopClear && actEvent)) begin
				inactFlag_q <= 1'b0;
			end
			if (linked && actEvent) begin
				armAct_q <= 1'b0;
			end else if (linked && inactEvent) begin
				armAct_q <= 1'b1;
			end
			// Awake follows the serviced event; loop mode services itself.
			if (actFlag_q && (statusRead || loopClear)) begin
				awake_q <= 1'b1;
			end else if (inactFlag_q && (statusRead || loopClear)) begin
				awake_q <= 1'b0;
			end
		end
	end

	assign actIrq   = actFlag_q && mode_q[MAD_MODE_IRQ_A];
	assign inactIrq = inactFlag_q && mode_q[MAD_MODE_IRQ_I];
	assign awake    = awake_q;

	// ========================================================================
	// AHB-Lite slave: zero wait states, always OKAY
	// ========================================================================
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			dpValid_q <= 1'b0;
			dpWrite_q <= 1'b0;
			dpAddr_q  <= '0;
		end else if (hready) begin
			dpValid_q <= hsel && htrans[1];
			dpWrite_q <= hwrite;
			dpAddr_q  <= haddr[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctl_q       <= MAD_CTL_RESET;
			mode_q      <= MAD_MODE_RESET;
			actThr_q    <= '0;
			inactThr_q  <= '0;
			actTime_q   <= '0;
			inactTime_q <= '0;
		end else if (dpValid_q && dpWrite_q) begin
			case (dpAddr_q)
				MAD_OFS_CONTROL:   ctl_q       <= hwdata[7:0];
				MAD_OFS_MODE:      mode_q      <= hwdata[9:0];
				MAD_OFS_ACT_THR:   actThr_q    <= hwdata[SAMPLE_W-1:0];
				MAD_OFS_INACT_THR: inactThr_q  <= hwdata[SAMPLE_W-1:0];
				MAD_OFS_ACT_TIME:  actTime_q   <= hwdata[MAD_ACT_TIME_W-1:0];
				MAD_OFS_INACT_TIM: inactTime_q <= hwdata[MAD_INACT_TIME_W-1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		hrdata = 32'h0000_0000;
		if (dpValid_q && !dpWrite_q) begin
			case (dpAddr_q)
				MAD_OFS_CONTROL:   hrdata = {24'h000000, ctl_q};
				MAD_OFS_MODE:      hrdata = {22'h000000, mode_q};
				MAD_OFS_ACT_THR:   hrdata[SAMPLE_W-1:0] = actThr_q;
				MAD_OFS_INACT_THR: hrdata[SAMPLE_W-1:0] = inactThr_q;
				MAD_OFS_ACT_TIME:  hrdata[MAD_ACT_TIME_W-1:0] = actTime_q;
				MAD_OFS_INACT_TIM: hrdata[MAD_INACT_TIME_W-1:0] = inactTime_q;
				MAD_OFS_STATUS:    hrdata[2:0] = {awake_q, inactFlag_q, actFlag_q};
				MAD_OFS_REFS:      hrdata[SAMPLE_W-1:0] = actRef_q[2];
				default:           hrdata = 32'h0000_0000;
			endcase
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ========================================================================
	// Assertions
	// ========================================================================
	property p_reset_off;
		@(posedge core_clk) $rose(nrst) |-> (actEn == MAD_EN_OFF && inactEn == MAD_EN_OFF);
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("detectors not off after reset");

	property p_act_flag;
		@(posedge core_clk) disable iff (!nrst) actEvent |=> actFlag_q;
	endproperty
	a_act_flag: assert property (p_act_flag) else $error("activity flag not set");

	property p_inact_flag;
		@(posedge core_clk) disable iff (!nrst) inactEvent |=> inactFlag_q;
	endproperty
	a_inact_flag: assert property (p_inact_flag) else $error("inactivity flag not set");

	property p_one_armed;
		@(posedge core_clk) disable iff (!nrst) linked |-> !(actArmed && inactArmed);
	endproperty
	a_one_armed: assert property (p_one_armed) else $error("both detectors armed in linked mode");

	property p_flag_hold;
		@(posedge core_clk) disable iff (!nrst)
			(actFlag_q && !statusRead && !loopClear) |=> actFlag_q;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("activity flag lost unread");

	property p_inact_ref_hold;
		@(posedge core_clk) disable iff (!nrst)
			(refValid_q && running && !inactEvent) |=> $stable(inactRef_q[0]);
	endproperty
	a_inact_ref_hold: assert property (p_inact_ref_hold) else $error("inactivity ref moved early");

	property p_wake_single;
		@(posedge core_clk) disable iff (!nrst)
			(sampleTick && wakeMode && actArmed && actHit) |=> actFlag_q;
	endproperty
	a_wake_single: assert property (p_wake_single) else $error("wake-up mode missed activity");

	property p_cnt_clear;
		@(posedge core_clk) disable iff (!nrst)
			(sampleTick && inactArmed && !inactHit) |=> (inactCnt_q == '0);
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("inactivity count not cleared");

	property p_awake_sleep;
		@(posedge core_clk) disable iff (!nrst)
			(inactFlag_q && !actFlag_q && statusRead) |=> !awake_q;
	endproperty
	a_awake_sleep: assert property (p_awake_sleep) else $error("awake not cleared");

endmodule

// >>> sim/mad_host_model.sv
/* Host model: AHB-Lite master that reads and writes the detector's registers.
   Assumes one slave whose hreadyout is fed back as hready. */
`timescale 1ns/1ps
module mad_host_model (
	// Clock
	input  wire logic        core_clk,
	// Bus master outputs
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	// Slave answer
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	// ==========================================
	// Single-word transfers
	// ==========================================
	initial begin
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// No latency is assumed; the bench watchdog is the only end to a wait.
	task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1'h1;
		haddr <= {24'h0, ofs};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge core_clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hready !== 1'h1);
		rd = hrdata;
	endtask
endmodule

// >>> sim/test_motion_activity_detector.sv
/* Self-checking bench of the motion activity detector.
   Assumes the host model drives the register bus and the bench feeds samples. */
`timescale 1ns/1ps
module test_motion_activity_detector;
	import mad_pkg::*;

	// ==========================================
	// Signals and instances
	// ==========================================
	localparam int SW = 14;
	localparam logic [SW-1:0] BIG = 14'h00C8;
	localparam logic [SW-1:0] LOW = 14'h000A;
	// Resting z reading that stands in for gravity in the referenced inactivity case.
	localparam logic [SW-1:0] REST = 14'h0400;
	typedef struct {
		logic [1:0]    en;
		logic [2:0]    axes;
		logic [SW-1:0] x;
		logic [SW-1:0] y;
		logic [SW-1:0] z;
		logic          act;
	} mad_row_t;
	logic          core_clk = 1'h0;
	logic          nrst = 1'h0;
	logic          sampleTick = 1'h0;
	logic [SW-1:0] sampleX = 14'h0;
	logic [SW-1:0] sampleY = 14'h0;
	logic [SW-1:0] sampleZ = 14'h0;
	logic          hsel;
	logic [31:0]   haddr;
	logic [1:0]    htrans;
	logic          hwrite;
	logic [2:0]    hsize;
	logic [31:0]   hwdata;
	logic [31:0]   hrdata;
	logic          hreadyout;
	logic          hresp;
	logic          actIrq;
	logic          inactIrq;
	logic          awake;
	logic [31:0]   v;
	int            miscompares = 0;
	int            testsRun = 0;
	mad_row_t      rows [6] = '{
		'{MAD_EN_ABS, 3'h7, 14'h0065, 14'h0000, 14'h0000, 1'h1},
		'{MAD_EN_ABS, 3'h7, 14'h0000, 14'h0000, 14'h0064, 1'h0},
		'{MAD_EN_ABS, 3'h7, 14'h0000, 14'h3F9B, 14'h0000, 1'h1},
		'{MAD_EN_ABS, 3'h7, 14'h0000, 14'h0000, 14'h00C8, 1'h1},
		'{MAD_EN_ABS, 3'h0, 14'h0065, 14'h0065, 14'h0065, 1'h0},
		'{MAD_EN_OFF, 3'h7, 14'h0065, 14'h0065, 14'h0065, 1'h0}
	};

	always #25 core_clk = ~core_clk;

	mad_motion_activity_detector #(.SAMPLE_W(SW)) DUT (.core_clk(core_clk), .nrst(nrst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .sampleTick(sampleTick), .sampleX(sampleX), .sampleY(sampleY),
		.sampleZ(sampleZ), .actIrq(actIrq), .inactIrq(inactIrq), .awake(awake));

	mad_host_model host (.core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata));

	// ==========================================
	// Helpers
	// ==========================================
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		testsRun++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		host.xfer(1'h1, ofs, d, v);
	endtask

	task automatic rd(input logic [7:0] ofs);
		host.xfer(1'h0, ofs, 32'h0, v);
	endtask

	function automatic logic [31:0] modeOf(logic [1:0] irq, logic [2:0] ax, logic [3:0] lo);
		return {22'h0, irq, 1'h0, ax, lo};
	endfunction

	// Standby first, so that each setup is a fresh entry into a running mode.
	task automatic cfg(input logic [31:0] ctl, input logic [31:0] mode);
		wr(MAD_OFS_MODE, 32'h0);
		wr(MAD_OFS_CONTROL, ctl);
		wr(MAD_OFS_MODE, mode);
	endtask

	task automatic rst(input logic [31:0] inTime);
		@(posedge core_clk);
		nrst <= 1'h0;
		repeat (4) @(posedge core_clk);
		nrst <= 1'h1;
		wr(MAD_OFS_ACT_THR, 32'h64);
		wr(MAD_OFS_ACT_TIME, 32'h1);
		wr(MAD_OFS_INACT_THR, 32'h32);
		wr(MAD_OFS_INACT_TIM, inTime);
	endtask

	// The trailing delay lets the flags of the tick edge settle before checks.
	task automatic smp(input logic [SW-1:0] x, input logic [SW-1:0] y, input logic [SW-1:0] z);
		@(posedge core_clk);
		sampleTick <= 1'h1;
		sampleX <= x;
		sampleY <= y;
		sampleZ <= z;
		@(posedge core_clk);
		sampleTick <= 1'h0;
		#1;
	endtask

	task automatic many(input int n, input logic [SW-1:0] a);
		repeat (n) smp(a, a, a);
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
		if (miscompares == 0 && testsRun > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares++;
		wrap_up();
	end

	// ==========================================
	// Scenarios
	// ==========================================
	initial begin
		rst(32'h4);
		rd(MAD_OFS_CONTROL);
		chk("control", 32'(MAD_CTL_RESET), v);
		rd(MAD_OFS_MODE);
		chk("mode", 32'(MAD_MODE_RESET), v);
		rd(MAD_OFS_STATUS);
		chk("status", 32'h4, v);
		chk("awake", 32'h1, 32'(awake));
		wr(8'h50, 32'hFFFFFFFF);
		rd(8'h50);
		chk("unmapped", 32'h0, v);
		chk("hresp", 32'h0, 32'(hresp));
		chk("hreadyout", 32'h1, 32'(hreadyout));
		wr(MAD_OFS_CONTROL, 32'h15);
		rd(MAD_OFS_CONTROL);
		chk("control", 32'h15, v);
		foreach (rows[i]) begin
			cfg(32'(rows[i].en), modeOf(2'h1, rows[i].axes, 4'h1));
			smp(rows[i].x, rows[i].y, rows[i].z);
			chk("actIrq", 32'(rows[i].act), 32'(actIrq));
			rd(MAD_OFS_STATUS);
			chk("act flag", 32'(rows[i].act), 32'(v[0]));
		end
		// Persistence: a miss restarts the count.
		wr(MAD_OFS_ACT_TIME, 32'h3);
		cfg(32'(MAD_EN_ABS), modeOf(2'h1, 3'h7, 4'h1));
		many(2, BIG);
		many(1, LOW);
		many(2, BIG);
		chk("actIrq", 32'h0, 32'(actIrq));
		many(1, BIG);
		chk("actIrq", 32'h1, 32'(actIrq));
		many(2, LOW);
		chk("actIrq", 32'h1, 32'(actIrq));
		rd(MAD_OFS_STATUS);
		chk("act flag", 32'h1, 32'(v[0]));
		rd(MAD_OFS_STATUS);
		chk("act flag", 32'h0, 32'(v[0]));
		cfg(32'(MAD_EN_ABS), modeOf(2'h1, 3'h7, 4'h2));
		many(1, BIG);
		chk("actIrq", 32'h1, 32'(actIrq));
		// Absolute inactivity, as a free-fall host would set it up.
		rst(32'h4);
		cfg(32'h4, modeOf(2'h2, 3'h7, 4'h1));
		many(3, LOW);
		smp(LOW, LOW, 14'h003C);
		many(3, LOW);
		chk("inactIrq", 32'h0, 32'(inactIrq));
		many(1, LOW);
		chk("inactIrq", 32'h1, 32'(inactIrq));
		rd(MAD_OFS_STATUS);
		chk("inact flag", 32'h1, 32'(v[1]));
		@(negedge core_clk);
		chk("awake", 32'h0, 32'(awake));
		// Referenced activity.
		rst(32'h1);
		cfg(32'h3, modeOf(2'h1, 3'h7, 4'h1));
		many(1, 14'h03E8);
		chk("actIrq", 32'h1, 32'(actIrq));
		rd(MAD_OFS_STATUS);
		rd(MAD_OFS_REFS);
		chk("reference", 32'h3E8, v);
		many(1, 14'h041A);
		chk("actIrq", 32'h0, 32'(actIrq));
		many(1, 14'h044D);
		chk("actIrq", 32'h1, 32'(actIrq));
		rd(MAD_OFS_REFS);
		chk("reference", 32'h44D, v);
		// Referenced inactivity, entered with a threshold above the resting reading.
		rst(32'h3);
		wr(MAD_OFS_INACT_THR, 32'h800);
		cfg(32'hC, modeOf(2'h2, 3'h7, 4'h1));
		smp(14'h0, 14'h0, REST);
		wr(MAD_OFS_INACT_THR, 32'h32);
		smp(14'h0, 14'h0, REST + 14'h003C);
		repeat (2) smp(14'h0, 14'h0, REST);
		chk("inactIrq", 32'h0, 32'(inactIrq));
		smp(14'h0, 14'h0, REST);
		chk("inactIrq", 32'h1, 32'(inactIrq));
		// Linked mode.
		rst(32'h2);
		cfg(32'h15, modeOf(2'h3, 3'h7, 4'h1));
		many(3, LOW);
		chk("inactIrq", 32'h0, 32'(inactIrq));
		many(1, BIG);
		chk("actIrq", 32'h1, 32'(actIrq));
		many(3, LOW);
		chk("inactIrq", 32'h0, 32'(inactIrq));
		rd(MAD_OFS_STATUS);
		chk("flags", 32'h1, 32'(v[1:0]));
		many(2, LOW);
		chk("inactIrq", 32'h1, 32'(inactIrq));
		many(1, BIG);
		chk("actIrq", 32'h0, 32'(actIrq));
		// Loop mode clears the opposite event by itself.
		rst(32'h2);
		cfg(32'h35, modeOf(2'h3, 3'h7, 4'h1));
		many(1, BIG);
		chk("actIrq", 32'h1, 32'(actIrq));
		many(2, LOW);
		chk("inactIrq", 32'h1, 32'(inactIrq));
		chk("actIrq", 32'h0, 32'(actIrq));
		wrap_up();
	end
endmodule
